// ### logic/burst2_split_port_sram.sv
`timescale 1ns/1ps
`include "burst2_sram_params.svh"
module burst2_split_port_sram
  import burst2_sram_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire logic [17:0] addr,
  input wire logic [17:0] wr_data,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic lane_lo_write_sel_n,
  input wire logic lane_hi_write_sel_n,
  input wire logic depth_strap_low_a,
  input wire logic depth_strap_low_b,
  output logic [17:0] rd_data,
  output logic rd_data_oe_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [45:0] pin_raw;
  logic [45:0] pin_s;
  logic [45:0] pin_rise;
  assign pin_raw = {depth_strap_low_b, depth_strap_low_a, lane_hi_write_sel_n,
                    lane_lo_write_sel_n, write_port_select_n, read_port_select_n,
                    wr_data, addr, c_clk_n, c_clk, k_clk_n, k_clk};

  // RL4 controls registered: every pin passes the same two flops as the clocks
  edge_sync #(.W(46)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(pin_raw),
    .dout(pin_s),
    .rise(pin_rise)
  );

  // decoded synchronised pins
  wire k_rise = pin_rise[0];
  wire kn_rise = pin_rise[1];
  wire c_s = pin_s[2];
  wire cn_s = pin_s[3];
  wire c_rise = pin_rise[2];
  wire cn_rise = pin_rise[3];
  wire [17:0] addr_s = pin_s[21:4];
  wire [17:0] data_s = pin_s[39:22];
  wire rps_n_s = pin_s[40];
  wire wps_n_s = pin_s[41];
  wire lane_lo_n_s = pin_s[42];
  wire lane_hi_n_s = pin_s[43];
  wire strap_a_s = pin_s[44];
  wire strap_b_s = pin_s[45];

  // ----------------------------------------------------------------
  // single-clock strap
  // ----------------------------------------------------------------
  logic [2:0] strap_cnt_reg;
  logic mode_done_reg;
  logic single_mode_reg;

  // RL18 mode caught once after reset, then frozen
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_cnt_reg <= 3'h0;
      mode_done_reg <= 1'b0;
      single_mode_reg <= 1'b0;
    end else if (!mode_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      if (strap_cnt_reg == `STRAP_WAIT) begin
        mode_done_reg <= 1'b1;
        single_mode_reg <= c_s & cn_s;
      end
    end
  end

  // RL5 output timing reference selection
  wire out_pos_rise = mode_done_reg & (single_mode_reg ? k_rise : c_rise);
  wire out_neg_rise = mode_done_reg & (single_mode_reg ? kn_rise : cn_rise);

  // ----------------------------------------------------------------
  // control register and array
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg;
  wire rd_en = ctrl_reg[`CTRL_RD_EN_BIT];
  wire wr_en = ctrl_reg[`CTRL_WR_EN_BIT];

  // RL2 RL20 one 36-bit entry per 18-bit address, lower word at offset 0
  burst_t mem [0:`DEPTH-1];

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  logic wr_act_reg;
  logic commit_reg;
  logic [17:0] wr_addr_reg;
  word_t wr_lo_data_reg;
  word_t wr_hi_data_reg;
  word_t wr_lo_mask_reg;
  word_t wr_hi_mask_reg;

  // RL13 RL17 lane selects expand to bit masks per word
  wire word_t lane_mask = {{`LANE_W{~lane_hi_n_s}}, {`LANE_W{~lane_lo_n_s}}};
  // RL12 a deselected write port starts nothing new
  wire wr_start = k_rise & ~wps_n_s & wr_en & mode_done_reg;

  // RL3 write words captured on alternate input edges
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_act_reg <= 1'b0;
      commit_reg <= 1'b0;
      wr_addr_reg <= 18'h00000;
      wr_lo_data_reg <= 18'h00000;
      wr_hi_data_reg <= 18'h00000;
      wr_lo_mask_reg <= 18'h00000;
      wr_hi_mask_reg <= 18'h00000;
    end else begin
      commit_reg <= 1'b0;
      // RL9 lower word on the start edge
      if (wr_start) begin
        wr_act_reg <= 1'b1;
        wr_lo_data_reg <= data_s;
        wr_lo_mask_reg <= lane_mask;
      end
      // RL10 RL15 write address and upper word on the K-bar edge
      if (kn_rise && wr_act_reg) begin
        wr_act_reg <= 1'b0;
        commit_reg <= 1'b1;
        wr_addr_reg <= addr_s;
        wr_hi_data_reg <= data_s;
        wr_hi_mask_reg <= lane_mask;
      end
    end
  end

  // RL11 RL14 masked merge keeps unselected lanes
  wire burst_t commit_mask = {wr_hi_mask_reg, wr_lo_mask_reg};
  wire burst_t commit_data = {wr_hi_data_reg, wr_lo_data_reg};
  wire burst_t commit_word = (mem[wr_addr_reg] & ~commit_mask) | (commit_data & commit_mask);

  // array update, storage has no reset
  always_ff @(posedge clock) begin
    if (commit_reg) begin
      mem[wr_addr_reg] <= commit_word;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic rd_go_reg;
  logic [17:0] rd_addr_reg;
  logic rd_ready_reg;
  burst_t rd_buf_reg;
  out_state_e out_state_reg;
  word_t launch_hi_reg;
  logic [17:0] q_reg;
  logic q_oe_n_reg;

  wire rd_start = k_rise & ~rps_n_s & rd_en & mode_done_reg;
  wire fetch_now = k_rise & rd_go_reg;
  // RL19 forward a write committing in this very cycle
  wire fwd_hit = commit_reg & (wr_addr_reg == rd_addr_reg);
  wire burst_t fetch_word = fwd_hit ? commit_word : mem[rd_addr_reg];
  wire launch_avail = rd_ready_reg | fetch_now;
  wire launch = out_pos_rise & launch_avail & (out_state_reg != OUT_LO);
  wire burst_t launch_word = rd_ready_reg ? rd_buf_reg : fetch_word;

  // RL6 read address latched on the start edge, fetched one K later
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_go_reg <= 1'b0;
      rd_addr_reg <= 18'h00000;
      rd_ready_reg <= 1'b0;
      rd_buf_reg <= 36'h000000000;
    end else begin
      if (k_rise) begin
        rd_go_reg <= rd_start;
        if (rd_start) begin
          rd_addr_reg <= addr_s;
        end
      end
      if (launch) begin
        rd_ready_reg <= fetch_now & rd_ready_reg;
      end else if (fetch_now) begin
        rd_ready_reg <= 1'b1;
      end
      if (fetch_now && !(launch && !rd_ready_reg)) begin
        rd_buf_reg <= fetch_word;
      end
    end
  end

  // RL7 RL8 RL16 output sequencer on the one-way read bus
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_state_reg <= OUT_IDLE;
      launch_hi_reg <= 18'h00000;
      q_reg <= 18'h00000;
      q_oe_n_reg <= 1'b1;
    end else begin
      case (out_state_reg)
        OUT_IDLE: begin
          if (launch) begin
            q_reg <= launch_word[17:0];
            launch_hi_reg <= launch_word[35:18];
            q_oe_n_reg <= 1'b0;
            out_state_reg <= OUT_LO;
          end
        end
        OUT_LO: begin
          if (out_neg_rise) begin
            q_reg <= launch_hi_reg;
            out_state_reg <= OUT_HI;
          end
        end
        OUT_HI: begin
          if (launch) begin
            q_reg <= launch_word[17:0];
            launch_hi_reg <= launch_word[35:18];
            out_state_reg <= OUT_LO;
          end else if (out_pos_rise) begin
            q_oe_n_reg <= 1'b1;
            out_state_reg <= OUT_IDLE;
          end
        end
        default: begin
          q_oe_n_reg <= 1'b1;
          out_state_reg <= OUT_IDLE;
        end
      endcase
    end
  end

  assign rd_data = q_reg;
  assign rd_data_oe_n = q_oe_n_reg;

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  logic [15:0] rd_count_reg;
  logic [15:0] wr_count_reg;
  logic [31:0] readdata_reg;
  logic waitreq_reg;

  // one wait state: waitrequest drops for exactly one cycle per request
  wire bus_req = avs_read | avs_write;
  wire bus_ack = bus_req & waitreq_reg;
  wire sel_ctrl = avs_address == `OFS_CTRL;
  wire sel_status = avs_address == `OFS_STATUS;
  wire sel_rdc = avs_address == `OFS_RD_COUNT;
  wire sel_wrc = avs_address == `OFS_WR_COUNT;
  // RL1 strap misuse is only reported, never used as address
  wire strap_fault = strap_a_s | strap_b_s;
  wire [31:0] status_word = {26'h0, wr_act_reg | commit_reg, ~q_oe_n_reg,
                             strap_fault, single_mode_reg, mode_done_reg, 1'b0};
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_reg} :
                       sel_status ? status_word :
                       sel_rdc ? {16'h0000, rd_count_reg} :
                       sel_wrc ? {16'h0000, wr_count_reg} : 32'h00000000;

  // bus answer and control write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      waitreq_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
      ctrl_reg <= `CTRL_RESET;
    end else begin
      waitreq_reg <= ~bus_ack;
      if (bus_ack && avs_read) begin
        readdata_reg <= rd_mux;
      end
      if (bus_ack && avs_write && sel_ctrl) begin
        ctrl_reg <= avs_writedata[1:0];
      end
    end
  end

  // burst counters, each cleared by a write to its own offset; a burst landing with the clear still counts
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_count_reg <= 16'h0000;
      wr_count_reg <= 16'h0000;
    end else begin
      if (bus_ack && avs_write && sel_rdc) begin
        rd_count_reg <= rd_start ? 16'h0001 : 16'h0000;
      end else if (rd_start) begin
        rd_count_reg <= rd_count_reg + 16'h0001;
      end
      if (bus_ack && avs_write && sel_wrc) begin
        wr_count_reg <= commit_reg ? 16'h0001 : 16'h0000;
      end else if (commit_reg) begin
        wr_count_reg <= wr_count_reg + 16'h0001;
      end
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitreq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_rd_addr_latch: assert property (rd_start |=> rd_go_reg && rd_addr_reg == $past(addr_s)) // RL6
    else $error("read address not latched");
  chk_wr_lo_word: assert property (wr_start |=> wr_act_reg && wr_lo_data_reg == $past(data_s)) // RL9
    else $error("lower write word not captured");
  chk_wr_addr_hi: assert property (kn_rise && wr_act_reg |=> commit_reg // RL10
    && wr_addr_reg == $past(addr_s) && wr_hi_data_reg == $past(data_s))
    else $error("write address or upper word not captured");
  chk_commit_single: assert property (commit_reg |=> !commit_reg) // RL11
    else $error("burst committed twice");
  chk_lane_mask: assert property (wr_start |=> wr_lo_mask_reg == // RL17
    {{9{!$past(lane_hi_n_s)}}, {9{!$past(lane_lo_n_s)}}})
    else $error("lane mask wrong");
  chk_lo_launch: assert property (launch |=> !q_oe_n_reg && q_reg == $past(launch_word[17:0])) // RL7
    else $error("lower read word not launched");
  chk_hi_follow: assert property (out_state_reg == OUT_LO && out_neg_rise // RL7
    |=> q_reg == $past(launch_hi_reg) && !q_oe_n_reg)
    else $error("upper read word not launched");
  chk_idle_float: assert property (out_state_reg == OUT_HI && out_pos_rise // RL8
    && !launch_avail |=> q_oe_n_reg)
    else $error("read bus not released");
  chk_mode_frozen: assert property (mode_done_reg |=> $stable(single_mode_reg)) // RL18
    else $error("clock mode changed");
  chk_forward: assert property (commit_reg // RL19
    |=> mem[$past(wr_addr_reg)] == $past(commit_word))
    else $error("latest write not held for reads");
  chk_bus_answer: assert property (bus_req && waitreq_reg |=> !waitreq_reg ##1 waitreq_reg)
    else $error("bus answer not one cycle");

  cov_read_burst: cover property (launch ##[1:40] (out_state_reg == OUT_HI));
  cov_write_commit: cover property (wr_start ##[1:40] commit_reg);
  cov_forward: cover property (fetch_now && fwd_hit);
  cov_bus_write: cover property (bus_ack && avs_write && sel_ctrl);
endmodule // burst2_split_port_sram

// ### pkg/burst2_sram_params.svh
// Behaviour
// RL1: controller holds both depth straps low
// RL2: two 256K x 18 arrays, two-word bursts
// RL3: write words captured on K and K-bar
// RL4: selects registered on input clock rises
// RL5: read data launched on output clock rises
// RL6: read select low latches read address
// RL7: lower word on C, upper on C-bar
// RL8: outputs float after C when idle
// RL9: write select low captures lower word
// RL10: K-bar latches write address, upper word
// RL11: commit 36-bit burst with byte masks
// RL12: deselected port finishes pending write only
// RL13: lane selects sampled with each word
// RL14: unselected lanes keep stored contents
// RL15: one address bus for both ports
// RL16: separate one-way read and write paths
// RL17: lane zero bits 8:0, one 17:9
// RL18: C pair high selects single-clock mode
// RL19: reads see the most recent write
// RL20: 18-bit address, lower word offset zero
`ifndef BURST2_SRAM_PARAMS_SVH
`define BURST2_SRAM_PARAMS_SVH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define ADDR_W 18
`define WORD_W 18
`define LANE_W 9
`define DEPTH 262144

// ----------------------------------------------------------------
// register map, byte addresses on the avalon slave
// ----------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_RD_COUNT 4'h8
`define OFS_WR_COUNT 4'hC
`define CTRL_RD_EN_BIT 0
`define CTRL_WR_EN_BIT 1
`define CTRL_RESET 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define STRAP_WAIT 3'h4

`endif

// ### pkg/burst2_sram_pkg.sv
package burst2_sram_pkg;
  // read output sequencer
  typedef enum logic [1:0] {OUT_IDLE, OUT_LO, OUT_HI} out_state_e;
  typedef logic [17:0] word_t;
  typedef logic [35:0] burst_t;
endpackage

// ### logic/edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser with rising-edge detect on the settled copy
module edge_sync #(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;
  logic [2:0] warm_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      warm_reg <= 3'h0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      warm_reg <= {warm_reg[1:0], 1'b1};
    end
  end

  // no false edge while the pipeline refills after reset
  assign dout = sync_reg;
  assign rise = sync_reg & ~prev_reg & {W{warm_reg[2]}};
endmodule // edge_sync

// ### sim/mem_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side memory controller model
// ----------------------------------------
module mem_ctrl_model (
  input wire logic clock,
  input wire logic [17:0] rd_data,
  input wire logic rd_data_oe_n,
  output logic k_clk,
  output logic k_clk_n,
  output logic [17:0] addr,
  output logic [17:0] wr_data,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic lane_lo_write_sel_n,
  output logic lane_hi_write_sel_n
);
  logic [2:0] phase_reg;
  // idle levels at time zero
  initial begin
    phase_reg = 3'h0;
    k_clk = 1'b0;
    k_clk_n = 1'b1;
    addr = 18'h00000;
    wr_data = 18'h00000;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    lane_lo_write_sel_n = 1'b1;
    lane_hi_write_sel_n = 1'b1;
  end
  // input clock pair, eight system clocks per period, k rise when phase 7 ends
  always @(posedge clock) begin
    phase_reg <= phase_reg + 3'h1;
    k_clk <= (phase_reg == 3'h7) || (phase_reg < 3'h3);
    k_clk_n <= !((phase_reg == 3'h7) || (phase_reg < 3'h3));
  end
  // wait for the edge that closes the given phase
  task automatic wait_phase(input logic [2:0] p);
    do @(posedge clock); while (phase_reg != p);
  endtask
  // one input clock period; mask bit0 is the low lane select, bit1 the high one
  task automatic link_cycle(input logic rd, input logic wr, input logic [17:0] ra,
    input logic [17:0] wa, input logic [17:0] lo, input logic [17:0] hi,
    input logic [1:0] mlo, input logic [1:0] mhi);
    wait_phase(3'h6);
    read_port_select_n <= !rd;
    write_port_select_n <= !wr;
    addr <= ra;
    wr_data <= lo;
    lane_lo_write_sel_n <= mlo[0];
    lane_hi_write_sel_n <= mlo[1];
    wait_phase(3'h2);
    // write address and upper word before the k-bar rise
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= wa;
    wr_data <= hi;
    lane_lo_write_sel_n <= mhi[0];
    lane_hi_write_sel_n <= mhi[1];
  endtask
  // released bus shows the inverse of the last value
  task automatic link_idle;
    wait_phase(3'h6);
    addr <= ~addr;
    wr_data <= ~wr_data;
    lane_lo_write_sel_n <= 1'b1;
    lane_hi_write_sel_n <= 1'b1;
  endtask
  // collect one burst from the read bus, bounded waits
  task automatic grab_read(output logic [17:0] lo, output logic [17:0] hi);
    int n;
    n = 0;
    while (rd_data_oe_n !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    lo = rd_data;
    repeat (3) @(posedge clock);
    hi = rd_data;
    n = 0;
    while (rd_data_oe_n !== 1'b1 && n < 12) begin
      @(posedge clock);
      n++;
    end
  endtask
endmodule // mem_ctrl_model

// ### sim/burst2_split_port_sram_bench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module burst2_split_port_sram_bench
  import burst2_sram_pkg::*;
();
  logic clock, sys_rst, c_clk, c_clk_n, k_clk, k_clk_n, oe_n, rps_n, wps_n, llo_n, lhi_n;
  logic strap_a, strap_b, avs_read, avs_write, avs_waitrequest, seen, dual_clk;
  logic [17:0] addr, wr_data, rd_data;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  word_t lo, hi, a, old_lo, old_hi;
  int n_fail, total_checks;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  burst2_split_port_sram u_burst2_split_port_sram (.clock(clock), .sys_rst(sys_rst),
    .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .addr(addr),
    .wr_data(wr_data), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .lane_lo_write_sel_n(llo_n), .lane_hi_write_sel_n(lhi_n), .depth_strap_low_a(strap_a),
    .depth_strap_low_b(strap_b), .rd_data(rd_data), .rd_data_oe_n(oe_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  mem_ctrl_model u_mem_ctrl_model (.clock(clock), .rd_data(rd_data), .rd_data_oe_n(oe_n),
    .k_clk(k_clk), .k_clk_n(k_clk_n), .addr(addr), .wr_data(wr_data),
    .read_port_select_n(rps_n), .write_port_select_n(wps_n), .lane_lo_write_sel_n(llo_n),
    .lane_hi_write_sel_n(lhi_n));
  // 20 MHz system clock
  always #25 clock = !clock;
  // output clock pair trails the input pair by one clock once the strap is dropped
  always @(posedge clock) begin
    if (dual_clk) begin
      c_clk <= k_clk;
      c_clk_n <= k_clk_n;
    end
  end
  // ----------------------------------------
  // bus and link tasks
  // ----------------------------------------
  // request held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic avs_rd(input logic [3:0] ad, output logic [31:0] v);
    avs_address <= ad;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clock);
    `CHK("avs_read_ack", 1'b1, avs_waitrequest)
  endtask
  task automatic avs_wr(input logic [3:0] ad, input logic [31:0] v);
    avs_address <= ad;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clock);
    `CHK("avs_write_ack", 1'b1, avs_waitrequest)
  endtask
  task automatic wr_burst(input word_t wa, input word_t l, input word_t h,
    input logic [1:0] ml, input logic [1:0] mh);
    u_mem_ctrl_model.link_cycle(1'b0, 1'b1, wa, wa, l, h, ml, mh);
    u_mem_ctrl_model.link_idle();
  endtask
  task automatic rd_check(input word_t ra, input word_t el, input word_t eh);
    u_mem_ctrl_model.link_cycle(1'b1, 1'b0, ra, ra, ~el, ~eh, 2'h3, 2'h3);
    u_mem_ctrl_model.link_idle();
    u_mem_ctrl_model.grab_read(lo, hi);
    `CHK("lower_word", el, lo)
    `CHK("upper_word", eh, hi)
    `CHK("bus_released", 1'b1, oe_n)
  endtask
  // expected word after a lane-masked write
  function automatic word_t merge(input logic [1:0] m, input word_t o, input word_t w);
    return {m[1] ? o[17:9] : w[17:9], m[0] ? o[8:0] : w[8:0]};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    total_checks = 0;
    clock = 1'b0;
    sys_rst = 1'b1;
    dual_clk = 1'b0;
    // output clock pair held high selects single-clock mode
    c_clk = 1'b1;
    c_clk_n = 1'b1;
    strap_a = 1'b0;
    strap_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (24) @(posedge clock);
    `CHK("oe_after_reset", 1'b1, oe_n)
    avs_rd(4'h0, d);
    `CHK("ctrl_reset", 32'h3, d)
    avs_rd(4'h4, d);
    `CHK("status_mode", 32'h6, d & 32'h3E)
    avs_wr(4'h4, 32'hFFFFFFFF);
    avs_rd(4'h4, d);
    `CHK("status_read_only", 32'h6, d & 32'h3E)
    avs_rd(4'h2, d);
    `CHK("unmapped", 32'h0, d)
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : 18'h15A5A;
      wr_burst(a, a ^ 18'h2AAAA, ~a, 2'h0, 2'h0);
      rd_check(a, a ^ 18'h2AAAA, ~a);
    end
    $display("test bursts done");
    // every lane select combination on both words
    old_lo = 18'h1E0F0;
    old_hi = 18'h0F1E1;
    for (int i = 0; i < 4; i++) begin
      wr_burst(18'h00123, old_lo, old_hi, 2'h0, 2'h0);
      wr_burst(18'h00123, ~old_lo, ~old_hi, i[1:0], 2'h3 - i[1:0]);
      rd_check(18'h00123, merge(i[1:0], old_lo, ~old_lo), merge(2'h3 - i[1:0], old_hi, ~old_hi));
    end
    $display("test lanes done");
    u_mem_ctrl_model.link_cycle(1'b0, 1'b0, 18'h00123, 18'h00123, 18'h0, 18'h0, 2'h0, 2'h0);
    u_mem_ctrl_model.link_idle();
    rd_check(18'h00123, merge(2'h3, old_lo, ~old_lo), merge(2'h0, old_hi, ~old_hi));
    // write enable off in control register
    avs_wr(4'h0, 32'h1);
    wr_burst(18'h00123, 18'h0, 18'h0, 2'h0, 2'h0);
    avs_wr(4'h0, 32'h3);
    rd_check(18'h00123, merge(2'h3, old_lo, ~old_lo), merge(2'h0, old_hi, ~old_hi));
    // read enable off: the bus must stay released
    avs_wr(4'h0, 32'h2);
    u_mem_ctrl_model.link_cycle(1'b1, 1'b0, 18'h00123, 18'h00123, 18'h0, 18'h0, 2'h3, 2'h3);
    seen = 1'b0;
    repeat (32) begin
      @(posedge clock);
      seen = seen | !oe_n;
    end
    `CHK("read_blocked", 1'b0, seen)
    avs_wr(4'h0, 32'h3);
    $display("test deselect done");
    // write then read of the same location on the next k rise
    avs_wr(4'h8, 32'h0);
    avs_wr(4'hC, 32'h0);
    u_mem_ctrl_model.link_cycle(1'b0, 1'b1, 18'h2F00D, 18'h2F00D, 18'h1234, 18'h3CAFE, 2'h0, 2'h0);
    u_mem_ctrl_model.link_cycle(1'b1, 1'b0, 18'h2F00D, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3);
    u_mem_ctrl_model.link_idle();
    u_mem_ctrl_model.grab_read(lo, hi);
    `CHK("forward_lo", 18'h1234, lo)
    `CHK("forward_hi", 18'h3CAFE, hi)
    avs_rd(4'h8, d);
    `CHK("read_count", 16'h1, d[15:0])
    avs_rd(4'hC, d);
    `CHK("write_count", 16'h1, d[15:0])
    $display("test forwarding done");
    // second reset with the output clock pair running selects two-clock mode
    sys_rst <= 1'b1;
    dual_clk <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (24) @(posedge clock);
    `CHK("oe_after_reset2", 1'b1, oe_n)
    avs_rd(4'h4, d);
    `CHK("status_dual", 32'h2, d & 32'h3E)
    rd_check(18'h2F00D, 18'h1234, 18'h3CAFE);
    $display("test dual clock done");
    final_report();
  end
endmodule // burst2_split_port_sram_bench
